// file: verilog/css_core_supply_sequencer.sv
module css_core_supply_sequencer
    import css_pkg::*;
#(
    parameter int unsigned CNT_W = 24,
    parameter int unsigned RR_CYC = RR_CYC_DEF,
    parameter int unsigned STG_CYC = STG_CYC_DEF,
    parameter int unsigned RD_CYC = RD_CYC_DEF,
    parameter int unsigned RAMP_CYC = RAMP_CYC_DEF,
    parameter int unsigned SW_HALF = SW_HALF_CYC_DEF
) (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic core_option_strap_i,
    input wire logic buck_intermediate_rail_ok_i,
    input wire logic micro_supply_ok_i,
    input wire logic core_mon_ov_i,
    input wire logic core_mon_uv_i,
    input wire logic [N_OUT-1:0] out_good_i,
    input wire logic sync_enable_i,
    input wire logic sync_invert_i,
    input wire logic [RD_SEL_W-1:0] reset_delay_sel_i,
    input wire logic out_req_i,
    input wire logic [N_OUT-1:0] out_cfg_i,
    input wire logic clr_ground_short_i,
    input wire logic clr_overvoltage_i,
    input wire logic clr_undervoltage_i,
    output logic standby_en_o,
    output logic buck_intermediate_rail_en_o,
    output logic micro_ldo_en_o,
    output logic [N_OUT-1:0] out_en_o,
    output logic ext_core_enable_out_o,
    output logic switcher_phase_ref_out_o,
    output logic reset_line_out_o,
    output logic init_state_o,
    output logic safe_state_o,
    output logic seq_halted_o,
    output logic seq_aborted_o,
    output logic ext_core_selected_o,
    output logic ground_short_flags_o,
    output logic overvoltage_flags_o,
    output logic undervoltage_flags_o,
    output logic [N_OUT-1:0] voltage_monitor_state_reg_o
);

    // ==========================================================
    // helpers
    // ==========================================================
    // saturating qualifier: cleared whenever its condition drops
    function automatic logic [CNT_W-1:0] qual_step(
        input logic [CNT_W-1:0] cnt,
        input logic cond,
        input logic [CNT_W-1:0] term
    );
        logic [CNT_W-1:0] res;
        res = cnt;
        if (!cond) begin
            res = '0;
        end else if (cnt < term) begin
            res = cnt + 1'b1;
        end
        return res;
    endfunction : qual_step

    localparam logic [CNT_W-1:0] RR_TERM = CNT_W'(RR_CYC);
    localparam logic [CNT_W-1:0] STG_TERM = CNT_W'(STG_CYC);
    localparam logic [CNT_W-1:0] RAMP_TERM = CNT_W'(RAMP_CYC);
    localparam logic [CNT_W-1:0] SW_TERM = CNT_W'(SW_HALF - 1);

    // ==========================================================
    // pin synchronisers (three stages, change once 2nd and 3rd agree)
    // ==========================================================
    logic [PIN_W-1:0] pin_raw;
    logic [PIN_W-1:0] s1_r, s2_r, s3_r, pin_r;
    logic [PIN_W-1:0] pin_nxt;

    assign pin_raw = {out_good_i, core_mon_uv_i, core_mon_ov_i, micro_supply_ok_i,
                      buck_intermediate_rail_ok_i, core_option_strap_i};

    always_comb begin
        pin_nxt = (s2_r & s3_r) | (pin_r & (s2_r | s3_r));
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s1_r <= '0;
            s2_r <= '0;
            s3_r <= '0;
            pin_r <= '0;
        end else begin
            s1_r <= pin_raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
            pin_r <= pin_nxt;
        end
    end

    // ==========================================================
    // sequencer, monitor and outputs
    // ==========================================================
    css_seq_type seq_r, seq_nxt;
    logic [1:0] idx_r, idx_nxt;
    logic [CNT_W-1:0] ramp_cnt_r, ramp_cnt_nxt;
    logic [CNT_W-1:0] ov_cnt_r, ov_cnt_nxt;
    logic [CNT_W-1:0] uv_cnt_r, uv_cnt_nxt;
    logic [CNT_W-1:0] stg_cnt_r, stg_cnt_nxt;
    logic [CNT_W-1:0] rd_cnt_r, rd_cnt_nxt;
    logic [CNT_W-1:0] sw_cnt_r, sw_cnt_nxt;
    logic sw_phase_r, sw_phase_nxt;
    logic ext_sel_r, ext_sel_nxt;
    logic sel_done_r, sel_done_nxt;
    logic core_up_r, core_up_nxt;
    logic standby_nxt, buck_intermediate_rail_nxt, micro_nxt, ext_en_nxt, sync_nxt, rst_nxt;
    logic init_nxt, safe_nxt, halt_nxt, abort_nxt;
    logic gs_nxt, ov_nxt, uv_nxt;
    logic [N_OUT-1:0] out_en_nxt, mon_nxt;
    logic [CNT_W-1:0] rd_term;
    logic ov_hit, uv_hit, stg_hit, core_ok, rd_cond, in_seq;

    assign rd_term = CNT_W'(RD_CYC) << reset_delay_sel_i;

    always_comb begin
        seq_nxt = seq_r;
        idx_nxt = idx_r;
        ext_sel_nxt = ext_sel_r;
        sel_done_nxt = sel_done_r;
        core_up_nxt = core_up_r;
        standby_nxt = standby_en_o;
        buck_intermediate_rail_nxt = buck_intermediate_rail_en_o;
        micro_nxt = micro_ldo_en_o;
        ext_en_nxt = ext_core_enable_out_o;
        out_en_nxt = out_en_o;
        halt_nxt = seq_halted_o;
        abort_nxt = seq_aborted_o;
        in_seq = (seq_r == SEQ_CORE) || (seq_r == SEQ_RAMP);

        // monitor qualification; a collapse from regulator thermal stop looks
        // the same at the input as any under-voltage
        ov_cnt_nxt = qual_step(ov_cnt_r, ext_sel_r & pin_r[PI_OV], RR_TERM);
        uv_cnt_nxt = qual_step(uv_cnt_r, core_up_r & pin_r[PI_UV], RR_TERM);
        stg_cnt_nxt = qual_step(stg_cnt_r, core_up_r & pin_r[PI_UV], STG_TERM);
        ov_hit = (ov_cnt_nxt == RR_TERM) && (seq_r != SEQ_SAFE);
        uv_hit = (uv_cnt_nxt == RR_TERM);
        stg_hit = (stg_cnt_nxt == STG_TERM) && (seq_r != SEQ_SAFE);
        ramp_cnt_nxt = qual_step(ramp_cnt_r, seq_r == SEQ_RAMP, RAMP_TERM);

        case (seq_r)
            SEQ_START: begin
                standby_nxt = 1'b1;
                buck_intermediate_rail_nxt = 1'b1;
                if (pin_r[PI_BUCK_INTERMEDIATE_RAIL]) begin
                    micro_nxt = 1'b1;
                    seq_nxt = SEQ_MICRO;
                end
            end
            SEQ_MICRO: begin
                if (pin_r[PI_MICRO]) begin
                    // open strap reads high through the pad pull-up
                    ext_sel_nxt = pin_r[PI_STRAP];
                    sel_done_nxt = 1'b1;
                    if (pin_r[PI_STRAP]) begin
                        ext_en_nxt = pin_r[PI_BUCK_INTERMEDIATE_RAIL];
                        seq_nxt = SEQ_CORE;
                    end else begin
                        out_en_nxt[OUT_REF] = 1'b1;
                        idx_nxt = OUT_REF;
                        seq_nxt = SEQ_RAMP;
                    end
                end
            end
            SEQ_CORE: begin
                ext_en_nxt = pin_r[PI_BUCK_INTERMEDIATE_RAIL];
                if (ext_core_enable_out_o && !pin_r[PI_UV] && !pin_r[PI_OV]) begin
                    core_up_nxt = 1'b1;
                    out_en_nxt[OUT_REF] = 1'b1;
                    idx_nxt = OUT_REF;
                    seq_nxt = SEQ_RAMP;
                end
            end
            SEQ_RAMP: begin
                if (pin_r[PI_GOOD + 32'(idx_r)]) begin
                    if (idx_r == OUT_LAST) begin
                        seq_nxt = SEQ_DONE;
                    end else begin
                        idx_nxt = idx_r + 2'h1;
                        out_en_nxt[idx_r + 2'h1] = 1'b1;
                    end
                    ramp_cnt_nxt = '0;
                end else if (ramp_cnt_nxt == RAMP_TERM) begin
                    halt_nxt = 1'b1;
                    seq_nxt = SEQ_HALT;
                end
            end
            SEQ_DONE, SEQ_HALT, SEQ_ABORT: begin
                if (out_req_i) begin
                    out_en_nxt = out_cfg_i;
                end
            end
            SEQ_SAFE: begin
                buck_intermediate_rail_nxt = 1'b0;
                micro_nxt = 1'b0;
                out_en_nxt = '0;
            end
            default: begin
                seq_nxt = SEQ_SAFE;
            end
        endcase

        // software request while ramping wins over the automatic sequence
        if (in_seq && out_req_i) begin
            out_en_nxt = out_cfg_i;
            abort_nxt = 1'b1;
            seq_nxt = SEQ_ABORT;
            if (seq_r == SEQ_CORE && !core_up_r) begin
                core_up_nxt = 1'b1;
            end
        end

        // protective events override everything above except standby, the option selection, the output index and the halt and abort flags
        if (ov_hit || stg_hit) begin
            seq_nxt = SEQ_SAFE;
            ext_en_nxt = 1'b0;
            core_up_nxt = 1'b0;
            out_en_nxt = '0;
            buck_intermediate_rail_nxt = 1'b0;
            micro_nxt = 1'b0;
        end else if (seq_r == SEQ_SAFE) begin
            ext_en_nxt = 1'b0;
        end

        // reset delay; short under-voltage keeps the regulator on
        core_ok = !ext_sel_r || (core_up_r && !uv_hit);
        rd_cond = sel_done_r && pin_r[PI_MICRO] && core_ok && (seq_nxt != SEQ_SAFE);
        rd_cnt_nxt = qual_step(rd_cnt_r, rd_cond, rd_term);
        rst_nxt = rd_cond && (rd_cnt_nxt == rd_term);
        init_nxt = !rst_nxt && (seq_nxt != SEQ_SAFE);
        safe_nxt = (seq_nxt == SEQ_SAFE);

        // sticky flags, a new event beats a same-cycle clear
        gs_nxt = stg_hit | (ground_short_flags_o & ~clr_ground_short_i);
        ov_nxt = ov_hit | (overvoltage_flags_o & ~clr_overvoltage_i);
        uv_nxt = uv_hit | (undervoltage_flags_o & ~clr_undervoltage_i);
        mon_nxt = out_en_nxt & pin_r[PI_GOOD +: N_OUT];

        // switching reference and its copy on the sync pin
        sw_cnt_nxt = (sw_cnt_r >= SW_TERM) ? '0 : sw_cnt_r + 1'b1;
        sw_phase_nxt = (sw_cnt_r >= SW_TERM) ? ~sw_phase_r : sw_phase_r;
        sync_nxt = sync_enable_i & (sw_phase_nxt ^ sync_invert_i);
    end

    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            seq_r <= SEQ_START;
            idx_r <= OUT_REF;
            ramp_cnt_r <= '0;
            ov_cnt_r <= '0;
            uv_cnt_r <= '0;
            stg_cnt_r <= '0;
            rd_cnt_r <= '0;
            sw_cnt_r <= '0;
            sw_phase_r <= 1'b0;
            ext_sel_r <= 1'b0;
            sel_done_r <= 1'b0;
            core_up_r <= 1'b0;
            standby_en_o <= 1'b0;
            buck_intermediate_rail_en_o <= 1'b0;
            micro_ldo_en_o <= 1'b0;
            out_en_o <= '0;
            ext_core_enable_out_o <= 1'b0;
            switcher_phase_ref_out_o <= 1'b0;
            reset_line_out_o <= 1'b0;
            init_state_o <= 1'b1;
            safe_state_o <= 1'b0;
            seq_halted_o <= 1'b0;
            seq_aborted_o <= 1'b0;
            ext_core_selected_o <= 1'b0;
            ground_short_flags_o <= 1'b0;
            overvoltage_flags_o <= 1'b0;
            undervoltage_flags_o <= 1'b0;
            voltage_monitor_state_reg_o <= '0;
        end else begin
            seq_r <= seq_nxt;
            idx_r <= idx_nxt;
            ramp_cnt_r <= ramp_cnt_nxt;
            ov_cnt_r <= ov_cnt_nxt;
            uv_cnt_r <= uv_cnt_nxt;
            stg_cnt_r <= stg_cnt_nxt;
            rd_cnt_r <= rd_cnt_nxt;
            sw_cnt_r <= sw_cnt_nxt;
            sw_phase_r <= sw_phase_nxt;
            ext_sel_r <= ext_sel_nxt;
            sel_done_r <= sel_done_nxt;
            core_up_r <= core_up_nxt;
            standby_en_o <= standby_nxt;
            buck_intermediate_rail_en_o <= buck_intermediate_rail_nxt;
            micro_ldo_en_o <= micro_nxt;
            out_en_o <= out_en_nxt;
            ext_core_enable_out_o <= ext_en_nxt;
            switcher_phase_ref_out_o <= sync_nxt;
            reset_line_out_o <= rst_nxt;
            init_state_o <= init_nxt;
            safe_state_o <= safe_nxt;
            seq_halted_o <= halt_nxt;
            seq_aborted_o <= abort_nxt;
            ext_core_selected_o <= ext_sel_nxt;
            ground_short_flags_o <= gs_nxt;
            overvoltage_flags_o <= ov_nxt;
            undervoltage_flags_o <= uv_nxt;
            voltage_monitor_state_reg_o <= mon_nxt;
        end
    end

endmodule : css_core_supply_sequencer

// file: inc/css_pkg.sv
package css_pkg;

    // ==========================================================
    // clock
    // ==========================================================
    localparam int unsigned CLK_PERIOD_NS = 20;
    localparam int unsigned CLK_KHZ = 50000;

    // ==========================================================
    // timing (figures in their own unit, counts derived)
    // ==========================================================
    // glitch_filter_time: least time, rounds up
    localparam int unsigned GLITCH_FILTER_TIME_NS = 10000;
    localparam int unsigned RR_CYC_DEF =
        (GLITCH_FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // ground_short_time: least time, rounds up
    localparam int unsigned GROUND_SHORT_TIME_US = 200;
    localparam int unsigned STG_CYC_DEF =
        (GROUND_SHORT_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // reset_hold_delay base step, scaled by the software select
    localparam int unsigned RESET_HOLD_DELAY_US = 10000;
    localparam int unsigned RD_CYC_DEF =
        (RESET_HOLD_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // allowed ramp time of one selectable output
    localparam int unsigned RAMP_TIMEOUT_US = 2000;
    localparam int unsigned RAMP_CYC_DEF =
        (RAMP_TIMEOUT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // pre-regulator switching frequency, half period in cycles
    localparam int unsigned SW_FREQ_KHZ = 2000;
    localparam int unsigned SW_HALF_CYC_DEF =
        (CLK_KHZ / (2 * SW_FREQ_KHZ) < 1) ? 1 : CLK_KHZ / (2 * SW_FREQ_KHZ);

    // ==========================================================
    // selectable outputs (reference, comm_ldo, tracker 1, tracker 2)
    // ==========================================================
    localparam int unsigned N_OUT = 4;
    localparam logic [1:0] OUT_REF = 2'h0;
    localparam logic [1:0] OUT_LAST = 2'h3;
    localparam int unsigned RD_SEL_W = 2;

    // ==========================================================
    // synchronised pin vector layout
    // ==========================================================
    localparam int unsigned PIN_W = 9;
    localparam int unsigned PI_STRAP = 0;
    localparam int unsigned PI_BUCK_INTERMEDIATE_RAIL = 1;
    localparam int unsigned PI_MICRO = 2;
    localparam int unsigned PI_OV = 3;
    localparam int unsigned PI_UV = 4;
    localparam int unsigned PI_GOOD = 5;

    typedef enum logic [2:0] {
        SEQ_START,
        SEQ_MICRO,
        SEQ_CORE,
        SEQ_RAMP,
        SEQ_DONE,
        SEQ_HALT,
        SEQ_ABORT,
        SEQ_SAFE
    } css_seq_type;

endpackage : css_pkg

// file: test/css_assertions.sv
module css_assertions
    import css_pkg::*;
#(
    parameter int unsigned RR_CYC = 4,
    parameter int unsigned STG_CYC = 20,
    parameter int unsigned RD_CYC = 30,
    parameter int unsigned SW_HALF = 2
) (
    input wire logic core_clk_i,
    input wire logic arst_n_i,
    input wire logic micro_supply_ok_i,
    input wire logic core_mon_ov_i,
    input wire logic core_mon_uv_i,
    input wire logic sync_enable_i,
    input wire logic sync_invert_i,
    input wire logic [RD_SEL_W-1:0] reset_delay_sel_i,
    input wire logic [N_OUT-1:0] out_en_o,
    input wire logic ext_core_enable_out_o,
    input wire logic switcher_phase_ref_out_o,
    input wire logic reset_line_out_o,
    input wire logic init_state_o,
    input wire logic safe_state_o,
    input wire logic ext_core_selected_o,
    input wire logic ground_short_flags_o,
    input wire logic overvoltage_flags_o,
    input wire logic undervoltage_flags_o
);
    // ==========================================================
    // run lengths of raw inputs and of the sync output level; lower bounds only, sync lag ignored
    // ==========================================================
    logic [15:0] ov_run_r, uv_run_r, mic_run_r, en_run_r, lvl_run_r;
    logic inv_q_r, ph_q_r;
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ov_run_r <= '0;
            uv_run_r <= '0;
            mic_run_r <= '0;
            en_run_r <= '0;
            lvl_run_r <= '0;
            inv_q_r <= 1'b0;
            ph_q_r <= 1'b0;
        end else begin
            ov_run_r <= core_mon_ov_i ? ov_run_r + 16'h1 : '0;
            uv_run_r <= core_mon_uv_i ? uv_run_r + 16'h1 : '0;
            mic_run_r <= micro_supply_ok_i ? mic_run_r + 16'h1 : '0;
            en_run_r <= (sync_enable_i && sync_invert_i == inv_q_r) ? en_run_r + 16'h1 : '0;
            inv_q_r <= sync_invert_i;
            ph_q_r <= switcher_phase_ref_out_o;
            lvl_run_r <= (switcher_phase_ref_out_o != ph_q_r) ? 16'h1 : lvl_run_r + 16'h1;
        end
    end

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!arst_n_i);

    // ==========================================================
    // monitor reactions
    // ==========================================================
    ov_filter_a: assert property ($rose(overvoltage_flags_o) |-> ov_run_r >= RR_CYC)
        else $error("overvoltage accepted too early");
    uv_filter_a: assert property ($rose(undervoltage_flags_o) |-> uv_run_r >= RR_CYC)
        else $error("undervoltage accepted too early");
    ov_shutdown_a: assert property ($rose(overvoltage_flags_o) |->
        safe_state_o && !ext_core_enable_out_o && out_en_o == '0)
        else $error("overvoltage without shutdown");
    uv_reset_a: assert property ($rose(undervoltage_flags_o) |->
        !reset_line_out_o && init_state_o)
        else $error("undervoltage without reset");
    short_safe_a: assert property ($rose(ground_short_flags_o) |->
        safe_state_o && !ext_core_enable_out_o && uv_run_r >= STG_CYC)
        else $error("ground short reaction wrong");
    enable_drop_a: assert property ($fell(ext_core_enable_out_o) |-> safe_state_o)
        else $error("enable dropped outside safe state");
    enable_cause_a: assert property ($rose(ext_core_enable_out_o) |->
        ext_core_selected_o && micro_supply_ok_i)
        else $error("enable raised without cause");
    ref_order_a: assert property ($rose(out_en_o[0]) && ext_core_selected_o |->
        !core_mon_uv_i)
        else $error("reference started before core");
    strap_hold_a: assert property (ext_core_selected_o |=> ext_core_selected_o)
        else $error("option selection changed");
    reset_delay_a: assert property ($rose(reset_line_out_o) |->
        mic_run_r >= (RD_CYC << reset_delay_sel_i))
        else $error("reset released too early");
    // ==========================================================
    // sync output
    // ==========================================================
    sync_idle_a: assert property (!sync_enable_i |=> !switcher_phase_ref_out_o)
        else $error("sync toggles while off");
    sync_half_a: assert property (switcher_phase_ref_out_o != ph_q_r &&
        en_run_r > 4 * SW_HALF |-> lvl_run_r == SW_HALF)
        else $error("sync half period wrong");

    cover property ($rose(overvoltage_flags_o));
    cover property ($rose(ground_short_flags_o));
    cover property ($rose(reset_line_out_o));
    cover property (switcher_phase_ref_out_o != ph_q_r && en_run_r > 4 * SW_HALF);
endmodule : css_assertions

bind css_core_supply_sequencer css_assertions #(
    .RR_CYC(RR_CYC), .STG_CYC(STG_CYC), .RD_CYC(RD_CYC), .SW_HALF(SW_HALF)
) u_chk (
    .core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .micro_supply_ok_i(micro_supply_ok_i),
    .core_mon_ov_i(core_mon_ov_i), .core_mon_uv_i(core_mon_uv_i),
    .sync_enable_i(sync_enable_i), .sync_invert_i(sync_invert_i),
    .reset_delay_sel_i(reset_delay_sel_i), .out_en_o(out_en_o),
    .ext_core_enable_out_o(ext_core_enable_out_o),
    .switcher_phase_ref_out_o(switcher_phase_ref_out_o), .reset_line_out_o(reset_line_out_o),
    .init_state_o(init_state_o), .safe_state_o(safe_state_o),
    .ext_core_selected_o(ext_core_selected_o), .ground_short_flags_o(ground_short_flags_o),
    .overvoltage_flags_o(overvoltage_flags_o), .undervoltage_flags_o(undervoltage_flags_o)
);

// file: test/css_partner_model.sv
module css_partner_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic slow_i,
    input wire logic buck_intermediate_rail_en_i,
    input wire logic micro_en_i,
    input wire logic ext_en_i,
    input wire logic [3:0] out_en_i,
    input wire logic [3:0] fail_mask_i,
    input wire logic ov_fault_i,
    input wire logic uv_fault_i,
    output logic buck_intermediate_rail_ok_o,
    output logic micro_ok_o,
    output logic core_ov_o,
    output logic core_uv_o,
    output logic [3:0] good_o
);
    // ==========================================================
    // rails follow their enables after a prompt or slow ramp
    // ==========================================================
    logic [6:0] pipe_r [8];
    logic [6:0] tap;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            for (int j = 0; j < 8; j++) begin
                pipe_r[j] <= '0;
            end
        end else begin
            // failed outputs never ramp, like a short to ground
            pipe_r[0] <= {out_en_i & ~fail_mask_i, ext_en_i, micro_en_i, buck_intermediate_rail_en_i};
            for (int j = 1; j < 8; j++) begin
                pipe_r[j] <= pipe_r[j-1];
            end
        end
    end
    assign tap = slow_i ? pipe_r[7] : pipe_r[1];
    assign buck_intermediate_rail_ok_o = tap[0];
    assign micro_ok_o = tap[1] & tap[0];
    // regulator thermal shutdown collapses the core rail
    assign core_uv_o = ~tap[2] | uv_fault_i;
    assign core_ov_o = ov_fault_i;
    assign good_o = tap[6:3];
endmodule : css_partner_model

// file: test/test_core_supply_sequencer.sv
module test_core_supply_sequencer
    import css_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    localparam int FILT = 4;
    localparam int GSH = 20;
    localparam int RDL = 30;
    localparam int SWH = 2;
    logic clk, rst_n, strap, sync_en, sync_inv, req, clr_gs, clr_ov, clr_uv;
    logic slow, ovf, uvf, pre_ok, mic_ok, c_ov, c_uv, stb_en, pre_en, mic_en, ext_en;
    logic ph_out, rst_line, init_st, safe, halted, aborted, ext_sel, gs_f, ov_f, uv_f;
    logic [1:0] sel;
    logic [3:0] cfg, fmask, good, oen, vmon, m;
    logic [31:0] r;
    int n_errors, n_checks, seed, t, cyc;

    css_core_supply_sequencer #(.RR_CYC(FILT), .STG_CYC(GSH), .RD_CYC(RDL), .RAMP_CYC(40),
        .SW_HALF(SWH)) DUT (.core_clk_i(clk), .arst_n_i(rst_n), .core_option_strap_i(strap),
        .buck_intermediate_rail_ok_i(pre_ok), .micro_supply_ok_i(mic_ok), .core_mon_ov_i(c_ov),
        .core_mon_uv_i(c_uv), .out_good_i(good), .sync_enable_i(sync_en),
        .sync_invert_i(sync_inv), .reset_delay_sel_i(sel), .out_req_i(req), .out_cfg_i(cfg),
        .clr_ground_short_i(clr_gs), .clr_overvoltage_i(clr_ov), .clr_undervoltage_i(clr_uv),
        .standby_en_o(stb_en), .buck_intermediate_rail_en_o(pre_en), .micro_ldo_en_o(mic_en), .out_en_o(oen),
        .ext_core_enable_out_o(ext_en), .switcher_phase_ref_out_o(ph_out),
        .reset_line_out_o(rst_line), .init_state_o(init_st), .safe_state_o(safe),
        .seq_halted_o(halted), .seq_aborted_o(aborted), .ext_core_selected_o(ext_sel),
        .ground_short_flags_o(gs_f), .overvoltage_flags_o(ov_f),
        .undervoltage_flags_o(uv_f), .voltage_monitor_state_reg_o(vmon));
    css_partner_model u_far (.clk_i(clk), .rst_n_i(rst_n), .slow_i(slow), .buck_intermediate_rail_en_i(pre_en),
        .micro_en_i(mic_en), .ext_en_i(ext_en), .out_en_i(oen), .fail_mask_i(fmask),
        .ov_fault_i(ovf), .uv_fault_i(uvf), .buck_intermediate_rail_ok_o(pre_ok), .micro_ok_o(mic_ok),
        .core_ov_o(c_ov), .core_uv_o(c_uv), .good_o(good));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ==========================================================
    // helpers
    // ==========================================================
    function automatic int exp_delay(input logic [1:0] s);
        return RDL << s;
    endfunction : exp_delay
    // sequence stops at the first output that never comes good
    function automatic logic [3:0] exp_en(input logic [3:0] mk);
        logic [3:0] e;
        e = 4'h0;
        for (int i = 0; i < 4; i++) begin
            e[i] = 1'b1;
            if (mk[i]) break;
        end
        return e;
    endfunction : exp_en
    task automatic end_of_test();
        if (n_errors == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_of_test
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    task automatic start_dut(input logic s, input logic sl, input logic [3:0] mk);
        rst_n = 1'b0;
        strap = s;
        slow = sl;
        fmask = mk;
        tick(6);
        rst_n = 1'b1;
    endtask : start_dut
    task automatic wait_rst();
        t = 0;
        while (rst_line !== 1'b1 && t < 2000) begin
            tick(1);
            t++;
        end
    endtask : wait_rst
    task automatic pulse_clr(input logic [2:0] w);
        {clr_gs, clr_ov, clr_uv} = w;
        tick(1);
        {clr_gs, clr_ov, clr_uv} = 3'h0;
        tick(1);
    endtask : pulse_clr
    task automatic count_hi(input int n);
        t = 0;
        repeat (n) begin
            tick(1);
            t += int'(ph_out);
        end
    endtask : count_hi

    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            end_of_test();
        end
    end
    // ==========================================================
    // main sequence
    // ==========================================================
    initial begin
        {rst_n, strap, sync_en, sync_inv, req, clr_gs, clr_ov, clr_uv} = 8'h0;
        {slow, ovf, uvf, sel, cfg, fmask} = 15'h0;
        seed = 68554;
        for (int i = 0; i < 5; i++) begin
            r = $random(seed);
            sel = r[1:0];
            m = (i == 0) ? 4'h0 : (i == 1) ? 4'h1 : r[7:4] & r[11:8];
            start_dut(r[2], r[3], m);
            wait_rst();
            chk(8'(t >= exp_delay(sel) && t <= exp_delay(sel) + 120), 8'h1);
            tick(150);
            chk(8'({stb_en, pre_en, mic_en, ext_en}), 8'({3'h7, r[2]}));
            chk(8'({halted, oen}), 8'({|m, exp_en(m)}));
            chk(8'(vmon), 8'(exp_en(m) & ~m));
            strap = ~r[2];
            tick(10);
            chk(8'(ext_sel), 8'(r[2]));
        end
        start_dut(r[4], 1'b1, 4'h0);
        t = 0;
        while (oen[0] !== 1'b1 && t < 500) begin
            tick(1);
            t++;
        end
        cfg = r[11:8];
        req = 1'b1;
        tick(1);
        req = 1'b0;
        tick(1);
        chk(8'({aborted, oen}), 8'({1'b1, cfg}));
        wait_rst();
        chk(8'(rst_line), 8'h1);
        start_dut(1'b1, 1'b0, 4'h0);
        wait_rst();
        count_hi(20);
        chk(8'(t), 8'h0);
        sync_en = 1'b1;
        sync_inv = r[8];
        tick(10);
        count_hi(8 * SWH);
        chk(8'(t), 8'(4 * SWH));
        sync_en = 1'b0;
        uvf = 1'b1;
        tick(2);
        uvf = 1'b0;
        tick(10);
        chk(8'(uv_f), 8'h0);
        uvf = 1'b1;
        tick(FILT + 8);
        chk(8'({uv_f, rst_line, init_st, ext_en}), 8'hb);
        uvf = 1'b0;
        wait_rst();
        chk(8'({rst_line, uv_f}), 8'h3);
        pulse_clr(3'h1);
        chk(8'(uv_f), 8'h0);
        uvf = 1'b1;
        tick(GSH + 10);
        chk(8'({gs_f, safe, ext_en}), 8'h6);
        uvf = 1'b0;
        pulse_clr(3'h4);
        chk(8'(gs_f), 8'h0);
        start_dut(1'b1, 1'b1, 4'h0);
        wait_rst();
        ovf = 1'b1;
        tick(2);
        ovf = 1'b0;
        tick(10);
        chk(8'(ov_f), 8'h0);
        ovf = 1'b1;
        tick(FILT + 8);
        chk(8'({ov_f, safe, ext_en, oen}), 8'h60);
        ovf = 1'b0;
        tick(2);
        chk(8'(ov_f), 8'h1);
        pulse_clr(3'h2);
        chk(8'(ov_f), 8'h0);
        end_of_test();
    end
endmodule : test_core_supply_sequencer
